// [verilog/wgf_top.sv]
/*
 * Write guard and fault summary bank of the power controller's
 * management command set: byte reads and writes, sticky fault flags,
 * fault index and the active-low alert pin.
 * Assumes commands come from a serial front end on CLOCK and fault
 * events from detectors on CLOCK, so neither is synchronised here.
 */
//
// Overview of operation
// - Guard, index and status commands can be read back at any time, guard or not; a clear-all read is refused.
// - With the guard bit clear, writes to all registers are taken.
// - With the guard bit set, only writes to the write guard itself are taken.
// - Any recorded fault drives the alert pin low.
// - Status registers can be read at any time without side effects.
// - Index bits 0 to 6 show which of the seven status registers hold a flag.
// - Index bit 7 shows a fault present and the alert pin held low.
// - Fault flags stay set until cleared, even when the condition ends.
// - Clear-all wipes every flag, and rewriting a status value clears those flags.
// - The fault index is eight bits and reads as zero after reset.
// - An index bit of one means its status register holds at least one flag.
`timescale 1ns/1ns
`include "wgf_defines.svh"

module wgf_top
    import wgf_pkg::*;
#(
    parameter int NUM_STATUS   = `WGF_STATUS_COUNT,
    parameter int STATUS_WIDTH = `WGF_STATUS_WIDTH
) (
    // Clock and reset
    input  wire logic                                    CLOCK,
    input  wire logic                                    RST_B,
    // Command request
    input  wire logic                                    CMD_VALID,
    output logic                                         CMD_READY,
    input  wgf_cmd_type                                  CMD,
    // Command answer
    output logic                                         RSP_VALID,
    output wgf_rsp_type                                  RSP,
    // Fault detectors
    input  wire logic [NUM_STATUS-1:0][STATUS_WIDTH-1:0] FAULT_EVT,
    // Alert pin
    output logic                                         FAULT_ALERT_N
);

    typedef struct packed {
        wgf_state_type          state;
        logic                   guard;
        logic [7:0]             index;
        wgf_rsp_type            rsp;
    } wgf_top_state_type;

    wgf_top_state_type                          top_ff;
    wgf_top_state_type                          nxt_top;
    wgf_dec_type                                dec;
    logic                                       take;
    logic                                       take_wr;
    logic                                       take_rd;
    logic                                       wr_open;
    logic [NUM_STATUS-1:0]                      clr_en;
    logic [STATUS_WIDTH-1:0]                    clr_mask;
    logic [NUM_STATUS-1:0][STATUS_WIDTH-1:0]    flags;
    logic [NUM_STATUS-1:0]                      reg_any;
    logic [7:0]                                 sel_flags;
    logic [7:0]                                 guard_byte;

    // Decode
    wgf_decode u_decode (
        .code (CMD.code),
        .dec  (dec)
    );

    // Handshake
    assign take      = CMD_VALID && (top_ff.state == WGF_IDLE);
    assign take_wr   = take && CMD.write;
    assign take_rd   = take && !CMD.write;
    assign CMD_READY = (top_ff.state == WGF_IDLE);
    assign RSP_VALID = (top_ff.state == WGF_REPLY);

    // A clearing write needs the guard open; the guard command never does
    assign wr_open = take_wr && !top_ff.guard;

    // Clear-all uses a full mask; a rewrite clears the bits written as one
    always_comb begin
        clr_mask = dec.clear_all ? '1 : CMD.wdata[STATUS_WIDTH-1:0];
        for (int i = 0; i < NUM_STATUS; i++) begin
            clr_en[i] = wr_open && (dec.clear_all || (dec.status && (dec.sel == 3'(i))));
        end
    end

    // Sticky status registers
    genvar g;
    generate
        for (g = 0; g < NUM_STATUS; g++) begin : g_status
            wgf_fault_reg #(
                .WIDTH (STATUS_WIDTH)
            ) u_fault_reg (
                .clk      (CLOCK),
                .rst_b    (RST_B),
                .set_evt  (FAULT_EVT[g]),
                .clr_en   (clr_en[g]),
                .clr_mask (clr_mask),
                .flags    (flags[g]),
                .any      (reg_any[g])
            );
        end
    endgenerate

    // Read data sources
    always_comb begin
        sel_flags  = `WGF_DATA_ZERO;
        guard_byte = `WGF_DATA_ZERO;
        guard_byte[`WGF_GUARD_BIT] = top_ff.guard;
        if (dec.status) begin
            sel_flags[STATUS_WIDTH-1:0] = flags[dec.sel];
        end
    end

    // Next state
    always_comb begin
        nxt_top = top_ff;

        // Index follows the flags; bit 7 rides with the alert pin
        nxt_top.index = `WGF_INDEX_RESET;
        nxt_top.index[NUM_STATUS-1:0] = reg_any;
        nxt_top.index[`WGF_ALERT_BIT] = |reg_any;

        case (top_ff.state)
            WGF_IDLE: begin
                if (take) begin
                    nxt_top.state    = WGF_REPLY;
                    nxt_top.rsp.ok   = 1'b0;
                    nxt_top.rsp.data = `WGF_DATA_ZERO;
                    if (CMD.write) begin
                        if (dec.guard) begin
                            // Always writable so protection can be lifted
                            nxt_top.guard  = CMD.wdata[`WGF_GUARD_BIT];
                            nxt_top.rsp.ok = 1'b1;
                        end else if (top_ff.guard) begin
                            nxt_top.rsp.ok = 1'b0;
                        end else begin
                            // Index is derived, so a write to it changes nothing
                            nxt_top.rsp.ok = dec.index || dec.status || dec.clear_all;
                        end
                    end else begin
                        if (dec.guard) begin
                            nxt_top.rsp.ok   = 1'b1;
                            nxt_top.rsp.data = guard_byte;
                        end else if (dec.index) begin
                            nxt_top.rsp.ok   = 1'b1;
                            nxt_top.rsp.data = top_ff.index;
                        end else if (dec.status) begin
                            nxt_top.rsp.ok   = 1'b1;
                            nxt_top.rsp.data = sel_flags;
                        end else begin
                            nxt_top.rsp.ok   = 1'b0;
                            nxt_top.rsp.data = `WGF_DATA_ZERO;
                        end
                    end
                end
            end
            WGF_REPLY: begin
                nxt_top.state = WGF_IDLE;
            end
            default: begin
                nxt_top.state = WGF_IDLE;
            end
        endcase
    end

    // Registers
    always_ff @(posedge CLOCK) begin
        if (!RST_B) begin
            top_ff.state    <= WGF_IDLE;
            top_ff.guard    <= `WGF_GUARD_RESET;
            top_ff.index    <= `WGF_INDEX_RESET;
            top_ff.rsp.ok   <= 1'b0;
            top_ff.rsp.data <= `WGF_DATA_ZERO;
        end else begin
            top_ff <= nxt_top;
        end
    end

    assign RSP = top_ff.rsp;

    // Pin mirrors index bit 7 so the two never disagree
    assign FAULT_ALERT_N = !top_ff.index[`WGF_ALERT_BIT];

    // Checks

    AST_READ_INDEX: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_rd && dec.index) |=> (RSP_VALID && RSP.ok && (RSP.data == $past(top_ff.index))))
        else $error("Index read did not return the index");

    AST_WRITE_OPEN: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_wr && !top_ff.guard && dec.status) |=> (RSP_VALID && RSP.ok))
        else $error("Open write to a status register refused");

    AST_WRITE_BLOCKED: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_wr && top_ff.guard && !dec.guard) |-> ((clr_en == '0) ##1 (RSP_VALID && !RSP.ok)))
        else $error("Guarded write was not ignored");

    AST_GUARD_WRITE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_wr && dec.guard) |=> (top_ff.guard == $past(CMD.wdata[`WGF_GUARD_BIT])))
        else $error("Guard write not taken");

    AST_GUARD_RESERVED: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_rd && dec.guard) |=> (RSP.data[6:0] == 7'h00 && RSP.data[7] == top_ff.guard))
        else $error("Guard reserved bits not zero");

    AST_ALERT_ON_FAULT: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (|FAULT_EVT) |-> ##2 (!FAULT_ALERT_N && top_ff.index[`WGF_ALERT_BIT]))
        else $error("Fault did not pull the alert pin low");

    AST_INDEX_MAP: assert property (@(posedge CLOCK) disable iff (!RST_B)
        1'b1 |=> (top_ff.index[NUM_STATUS-1:0] == $past(reg_any)))
        else $error("Index bits do not follow the status registers");

    AST_STATUS_READ: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_rd && dec.status) |-> ((clr_en == '0) ##1 (RSP.ok && RSP.data == $past(sel_flags))))
        else $error("Status read wrong or disturbed the flags");

    AST_CLEAR_ALL: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_wr && dec.clear_all && !top_ff.guard && (FAULT_EVT == '0)) |-> ##2 FAULT_ALERT_N)
        else $error("Clear-all left the alert pin low");

    AST_REWRITE_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (wr_open && dec.status && (CMD.wdata == flags[dec.sel]) && (FAULT_EVT[dec.sel] == '0))
        |=> (flags[$past(dec.sel)] == '0))
        else $error("Rewrite did not clear the status register");

    AST_ALERT_RELEASE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (reg_any == '0) |=> (FAULT_ALERT_N && top_ff.index == `WGF_INDEX_RESET))
        else $error("Alert pin held with no flags set");

    // Reset values are checked with reset active, so no disable here
    AST_RESET_STATE: assert property (@(posedge CLOCK)
        !RST_B |=> (top_ff.index == `WGF_INDEX_RESET && !top_ff.guard && FAULT_ALERT_N))
        else $error("Reset state wrong");

    AST_READY_IN_ANSWER: assert property (@(posedge CLOCK) disable iff (!RST_B)
        RSP_VALID |-> !CMD_READY)
        else $error("Ready high during answer");

    AST_ANSWER_ONCE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        take |=> (RSP_VALID ##1 !RSP_VALID))
        else $error("Answer strobe not a single cycle");

    AST_READ_GUARDED: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_rd && top_ff.guard && (dec.guard || dec.index || dec.status)) |=> RSP.ok)
        else $error("Read refused while guarded");

    AST_UNKNOWN_REFUSED: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take && !(dec.guard || dec.index || dec.status || dec.clear_all))
        |=> (RSP_VALID && !RSP.ok && RSP.data == `WGF_DATA_ZERO))
        else $error("Unknown command not refused");

    AST_GUARD_HOLD: assert property (@(posedge CLOCK) disable iff (!RST_B)
        !(take_wr && dec.guard) |=> $stable(top_ff.guard))
        else $error("Guard changed without a guard write");

    AST_GUARDED_NO_CLEAR: assert property (@(posedge CLOCK) disable iff (!RST_B)
        top_ff.guard |-> (clr_en == '0))
        else $error("Clear enabled while guarded");

    AST_INDEX_WRITE_NOP: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (take_wr && dec.index) |-> (clr_en == '0))
        else $error("Index write touched the flags");

    AST_ALERT_BIT: assert property (@(posedge CLOCK) disable iff (!RST_B)
        top_ff.index[`WGF_ALERT_BIT] == (|top_ff.index[NUM_STATUS-1:0]))
        else $error("Index bit 7 disagrees with the index bits");

    AST_INDEX_STICKY: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (clr_en == '0) |=> ((reg_any & $past(reg_any)) == $past(reg_any)))
        else $error("Index bit dropped without a clear");

    AST_CLEAR_ALL_FLAGS: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (wr_open && dec.clear_all && (FAULT_EVT == '0)) |=> (reg_any == '0))
        else $error("Clear-all left flags set");

    AST_REWRITE_ENABLE: assert property (@(posedge CLOCK) disable iff (!RST_B)
        (wr_open && dec.status) |-> clr_en[dec.sel])
        else $error("Open status rewrite did not enable a clear");

endmodule

// [verilog/wgf_defines.svh]
/*
 * Command codes, field positions and reset values of the write guard
 * and fault summary bank.
 * Assumes inclusion by bare name from each design file that needs it.
 */
`ifndef WGF_DEFINES_SVH
`define WGF_DEFINES_SVH

// Command codes
`define WGF_CMD_WRITE_GUARD   8'h10
`define WGF_CMD_FAULT_INDEX   8'hC0
`define WGF_CMD_STATUS_FIRST  8'hD2
`define WGF_CMD_STATUS_LAST   8'hD8
`define WGF_CMD_CLEAR_ALL     8'h03

// Field positions
`define WGF_GUARD_BIT         7
`define WGF_ALERT_BIT         7
`define WGF_STATUS_COUNT      7
`define WGF_STATUS_WIDTH      8

// Reset values
`define WGF_GUARD_RESET       1'h0
`define WGF_INDEX_RESET       8'h00
`define WGF_STATUS_RESET      8'h00
`define WGF_DATA_ZERO         8'h00
`define WGF_SEL_ZERO          3'h0

`endif

// [verilog/wgf_pkg.sv]
/*
 * Types shared by the write guard and fault summary bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wgf_pkg;

    // One byte command from the management bus front end
    typedef struct packed {
        logic       write;
        logic [7:0] code;
        logic [7:0] wdata;
    } wgf_cmd_type;

    // Answer to one command
    typedef struct packed {
        logic       ok;
        logic [7:0] data;
    } wgf_rsp_type;

    // Decoded command
    typedef struct packed {
        logic       guard;
        logic       index;
        logic       status;
        logic [2:0] sel;
        logic       clear_all;
    } wgf_dec_type;

    typedef enum logic [1:0] {
        WGF_IDLE  = 2'b01,
        WGF_REPLY = 2'b10
    } wgf_state_type;

endpackage

// [verilog/wgf_decode.sv]
/*
 * Command code decoder for the fault summary bank.
 * Assumes a command code valid in the same cycle; purely combinational.
 */
`timescale 1ns/1ns
`include "wgf_defines.svh"

module wgf_decode
    import wgf_pkg::*;
(
    // Command code
    input  wire logic [7:0]  code,
    // Decoded fields
    output wgf_dec_type      dec
);

    logic [7:0] offset;

    always_comb begin
        offset        = code - `WGF_CMD_STATUS_FIRST;
        dec.guard     = (code == `WGF_CMD_WRITE_GUARD);
        dec.index     = (code == `WGF_CMD_FAULT_INDEX);
        dec.status    = (code >= `WGF_CMD_STATUS_FIRST) && (code <= `WGF_CMD_STATUS_LAST);
        dec.sel       = offset[2:0];
        dec.clear_all = (code == `WGF_CMD_CLEAR_ALL);
    end

endmodule

// [verilog/wgf_fault_reg.sv]
/*
 * One sticky fault status register.
 * Assumes set events on the same clock; clearing is gated by the caller.
 */
`timescale 1ns/1ns
`include "wgf_defines.svh"

module wgf_fault_reg
    import wgf_pkg::*;
#(
    parameter int WIDTH = `WGF_STATUS_WIDTH
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // Fault events and clearing
    input  wire logic [WIDTH-1:0]  set_evt,
    input  wire logic              clr_en,
    input  wire logic [WIDTH-1:0]  clr_mask,
    // Stored flags
    output logic      [WIDTH-1:0]  flags,
    output logic                   any
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } wgf_flag_state_type;

    wgf_flag_state_type flag_ff;
    wgf_flag_state_type nxt_flag;

    // Set wins over a clear in the same cycle
    always_comb begin
        nxt_flag       = flag_ff;
        nxt_flag.flags = (flag_ff.flags & ~(clr_en ? clr_mask : '0)) | set_evt;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            flag_ff.flags <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign flags = flag_ff.flags;
    assign any   = |flag_ff.flags;

    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
        !clr_en |=> ((flags & $past(flags)) == $past(flags)))
        else $error("Fault flag dropped without a clear");

endmodule

// [dv/wgf_host.sv]
/*
 * Partner model: the management bus controller that issues byte commands.
 * Assumes the bank raises its answer on the taking edge and is driven
 * from the bench 1 ns after a rising edge.
 */
`timescale 1ns/1ns

module wgf_host
    import wgf_pkg::*;
(
    // Clock
    input  wire logic   clk,
    // Request
    output logic        cmd_valid,
    input  wire logic   cmd_ready,
    output wgf_cmd_type cmd,
    // Answer
    input  wire logic   rsp_valid,
    input  wgf_rsp_type rsp
);
    initial begin
        cmd_valid = 1'b0;
        cmd = '0;
    end

    // Request held until taken; bounded wait so a stuck ready cannot hang
    task automatic xfer(input logic w, input logic [7:0] code, input logic [7:0] wd,
                        output wgf_rsp_type r, output logic hit);
        int n;
        n = 0;
        cmd_valid = 1'b1;
        cmd = '{write: w, code: code, wdata: wd};
        while (cmd_ready !== 1'b1 && n < 8) begin
            n++;
            @(posedge clk);
            #1;
        end
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
        // Idle bus scrambled so a stale command never looks valid
        cmd = ~cmd;
        hit = (rsp_valid === 1'b1);
        r = rsp;
    endtask
endmodule

// [dv/testbench.sv]
/*
 * Self-checking bench of the write guard and fault summary bank,
 * compared against an integer model of guard, sticky flags and index.
 * Assumes the partner model in wgf_host and the design package.
 */
`timescale 1ns/1ns

module testbench;
    import wgf_pkg::*;

    logic            CLOCK;
    logic            RST_B;
    logic            CMD_VALID;
    logic            CMD_READY;
    logic            RSP_VALID;
    logic            FAULT_ALERT_N;
    wgf_cmd_type     CMD;
    wgf_rsp_type     RSP;
    logic [6:0][7:0] FAULT_EVT = '0;
    int              n_mismatch = 0;
    int              num_checks = 0;
    int              flags[7];
    int              guard = 0;
    logic [31:0]     lfsr = 32'hE774ED26;

    wgf_top i_wgf_top (.CLOCK(CLOCK), .RST_B(RST_B), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY),
                       .CMD(CMD), .RSP_VALID(RSP_VALID), .RSP(RSP), .FAULT_EVT(FAULT_EVT),
                       .FAULT_ALERT_N(FAULT_ALERT_N));
    wgf_host host (.clk(CLOCK), .cmd_valid(CMD_VALID), .cmd_ready(CMD_READY), .cmd(CMD),
                   .rsp_valid(RSP_VALID), .rsp(RSP));

    function automatic logic [31:0] lfsr_next(logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
    endfunction

    function automatic logic [7:0] index();
        logic [7:0] v;
        v = 8'h00;
        foreach (flags[i]) v[i] = (flags[i] != 0);
        v[7] = |v[6:0];
        return v;
    endfunction

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // One command against the model, then the pin once the index settles
    task automatic acc(logic w, logic [7:0] code, logic [7:0] wd);
        wgf_rsp_type r;
        logic        hit;
        logic        eok;
        logic [7:0]  ed;
        int          s;
        s = code - 8'hD2;
        eok = 1'b0;
        ed = 8'h00;
        if (code == 8'h10) begin
            eok = 1'b1;
            ed = {guard[0], 7'h00};
            if (w) guard = wd[7];
        end else if (code == 8'hC0) begin
            eok = !w || !guard;
            ed = index();
        end else if (code >= 8'hD2 && code <= 8'hD8) begin
            eok = !w || !guard;
            ed = flags[s];
            if (w && eok) flags[s] &= ~wd;
        end else if (code == 8'h03 && w) begin
            eok = !guard;
            if (eok) foreach (flags[i]) flags[i] = 0;
        end
        host.xfer(w, code, wd, r, hit);
        check("answer strobe", hit, 1);
        check("ready in answer", CMD_READY, 0);
        check("answer ok", r.ok, eok);
        if (!w && (eok || code != 8'h03)) check("read data", r.data, ed);
        @(posedge CLOCK);
        #1;
        check("ready after answer", CMD_READY, 1);
        check("alert pin", FAULT_ALERT_N, (index() >> 7) == 0);
    endtask

    task automatic fault(int r, logic [7:0] b);
        FAULT_EVT[r] = b;
        flags[r] |= b;
        @(posedge CLOCK);
        #1;
        FAULT_EVT = '0;
        @(posedge CLOCK);
        #1;
        check("alert after event", FAULT_ALERT_N, (index() >> 7) == 0);
    endtask

    task automatic conclude();
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    // Whole run is well under a thousand cycles
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end

    initial begin
        RST_B = 1'b0;
        repeat (12) @(posedge CLOCK);
        #1;
        RST_B = 1'b1;
        check("alert at reset", FAULT_ALERT_N, 1);
        acc(0, 8'h10, 8'h00);
        acc(0, 8'hC0, 8'h00);
        acc(0, 8'h55, 8'h00);
        acc(0, 8'h03, 8'h00);
        repeat (24) begin
            lfsr = lfsr_next(lfsr);
            fault(lfsr % 7, lfsr[15:8]);
            acc(1, 8'h10, lfsr[23:16]);
            acc(0, 8'hC0, 8'h00);
            for (int i = 0; i < 7; i++) begin
                if (index() >> i & 1) acc(0, 8'hD2 + i, 8'h00);
            end
            // Rewrite of the held value clears only when the guard is open
            acc(1, 8'hD2 + lfsr[26:24] % 7, flags[lfsr[26:24] % 7]);
            acc(1, 8'hC0, 8'hFF);
            acc(0, 8'h10, 8'h00);
        end
        fault(3, 8'h81);
        acc(1, 8'h10, 8'hFF);
        acc(1, 8'h03, 8'h00);
        acc(0, 8'hD5, 8'h00);
        acc(1, 8'h10, 8'h00);
        acc(1, 8'h03, 8'h00);
        acc(0, 8'hC0, 8'h00);
        conclude();
    end
endmodule
